// ==== dv/gcc_rx_model.sv ====
// behavioural receiver answering on the companion serial bus
`timescale 1ns/1ps
module gcc_rx_model
(
  // clock and bus lines
  input wire logic   clk,
  input wire logic   scl,
  input wire logic   sda,
  // open-drain pull and last byte seen
  output logic       sda_low,
  output logic [7:0] got
);
  localparam logic [7:0] TX_BYTE = 8'ha5;
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic       first = 1'b0;
  logic       rd = 1'b0;
  logic [3:0] cnt = 4'h0;
  initial sda_low = 1'b0; // only pulls low, never holds a line high
  always @(posedge clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda)
    begin
      // the start's own clock fall wraps this to zero
      cnt <= 4'hf;
      first <= 1'b1;
      sda_low <= 1'b0;
    end
    else if (scl && !scl_q && cnt < 4'h8)
      got <= {got[6:0], sda};
    else if (!scl && scl_q)
    begin
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h7)
        sda_low <= first || !rd; // acks address and written bytes
      else if (cnt == 4'h8)
      begin
        first <= 1'b0;
        rd <= first ? got[0] : rd;
        // a transmitting slave stops once the master answers not-acknowledge
        sda_low <= (first ? got[0] : rd && !sda) && !TX_BYTE[7];
      end
      else
        sda_low <= rd && !first && !TX_BYTE[4'h6 - cnt];
    end
  end
endmodule

// ==== dv/gcc_sva.sv ====
// port assertions for the companion control block
`timescale 1ns/1ps
module gcc_sva
  import gcc_pkg::*;
(
  // clock and reset
  input wire logic     CLK,
  input wire logic     RESETN,
  // observed ports
  input wire gcc_cfg_s CFG_OUT,
  input wire logic     HOST_CMD_READY,
  input wire logic     COMPANION_SERIAL_BUS_SDA_OE,
  input wire logic     RECEIVER_SUPPLY_ENABLE_PIN_O,
  input wire logic     RECEIVER_DATA_READY_PIN_I,
  input wire logic     RECEIVER_DATA_READY_PIN_PD_EN,
  input wire logic     CLOCK_SHARING_PIN_O,
  input wire logic     RTC_SYNC_IN,
  input wire logic     WAKE_EVENT,
  input wire logic     IDLE_REQ
);
  logic rdy_on;
  logic cs_drv;
  assign rdy_on = CFG_OUT.ready_func == FN_READY && CFG_OUT.rx_power && CFG_OUT.io_cfg == 8'h10;
  assign cs_drv = CFG_OUT.clksh_func == FN_CLKSH && CFG_OUT.rx_power && CFG_OUT.io_cfg == 8'h20
                  && RTC_SYNC_IN;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  reset_cfg_a: assert property ($rose(RESETN) |-> CFG_OUT == CFG_RESET)
    else $error("config not at reset value");
  supply_pin_a: assert property (RECEIVER_SUPPLY_ENABLE_PIN_O == CFG_OUT.rx_power)
    else $error("supply pin wrong");
  ready_pd_a: assert property (RECEIVER_DATA_READY_PIN_PD_EN == !rdy_on)
    else $error("pull-down wrong");
  clksh_pin_a: assert property (CLOCK_SHARING_PIN_O == $past(cs_drv))
    else $error("clock sharing pin wrong");
  master_only_a: assert property ($rose(COMPANION_SERIAL_BUS_SDA_OE) |-> !HOST_CMD_READY)
    else $error("data line pulled while idle");
  wake_sync_a: assert property ($rose(RECEIVER_DATA_READY_PIN_I) |-> !WAKE_EVENT [*3])
    else $error("wake too early");
  wake_time_a: assert property ($rose(RECEIVER_DATA_READY_PIN_I) && rdy_on
    |-> ##[3:4] WAKE_EVENT) else $error("wake missing");
  idle_cfg_a: assert property (IDLE_REQ |-> $past(CFG_OUT.power_save))
    else $error("idle without power saving");
  idle_busy_a: assert property (!HOST_CMD_READY |=> !IDLE_REQ)
    else $error("idle while busy");
endmodule

// ==== dv/gcc_top_tb_top.sv ====
// self-checking bench for the companion control block
`timescale 1ns/1ps
module gcc_top_tb_top
  import gcc_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cfg_we = 1'b0;
  gcc_cfg_s   cfg_in = CFG_RESET;
  gcc_cfg_s   cfg_out;
  logic       cmd_v = 1'b0;
  gcc_cmd_s   cmd = '0;
  logic       rdy, rsp_v, rsp_nk, scl_oe, sda_oe, sda_low;
  logic [7:0] rsp_d, got;
  logic       sup_o, sup_oe, dr_oe, pd, cs_o, cs_oe, wake, idle;
  logic       scl_o, sda_o, aid_valid, aid_busy;
  logic       dr = 1'b0;
  logic       rtc = 1'b1;
  logic       ack = 1'b0;
  logic       aid_req = 1'b0;
  int         fails = 0;
  int         total_checks = 0;
  wire logic  scl = !scl_oe;
  wire logic  sda = !(sda_oe | sda_low);
  always #2 clk = ~clk;
  gcc_top u_dut
  (
    .CLK(clk),
    .RESETN(rst_n),
    .CFG_WE(cfg_we),
    .CFG_IN(cfg_in),
    .CFG_OUT(cfg_out),
    .HOST_CMD_VALID(cmd_v),
    .HOST_CMD(cmd),
    .HOST_CMD_READY(rdy),
    .HOST_RSP_VALID(rsp_v),
    .HOST_RSP_DATA(rsp_d),
    .HOST_RSP_NACK(rsp_nk),
    .COMPANION_SERIAL_BUS_SCL_I(scl),
    .COMPANION_SERIAL_BUS_SCL_O(scl_o),
    .COMPANION_SERIAL_BUS_SCL_OE(scl_oe),
    .COMPANION_SERIAL_BUS_SDA_I(sda),
    .COMPANION_SERIAL_BUS_SDA_O(sda_o),
    .COMPANION_SERIAL_BUS_SDA_OE(sda_oe),
    .RECEIVER_SUPPLY_ENABLE_PIN_O(sup_o),
    .RECEIVER_SUPPLY_ENABLE_PIN_OE(sup_oe),
    .RECEIVER_DATA_READY_PIN_I(dr),
    .RECEIVER_DATA_READY_PIN_OE(dr_oe),
    .RECEIVER_DATA_READY_PIN_PD_EN(pd),
    .CLOCK_SHARING_PIN_O(cs_o),
    .CLOCK_SHARING_PIN_OE(cs_oe),
    .RTC_SYNC_IN(rtc),
    .WAKE_EVENT(wake),
    .WAKE_ACK(ack),
    .IDLE_REQ(idle),
    .AID_SAVE_REQ(aid_req),
    .AID_VALID(aid_valid),
    .AID_BUSY(aid_busy)
  );
  gcc_rx_model u_rx
  (
    .clk(clk),
    .scl(scl),
    .sda(sda),
    .sda_low(sda_low),
    .got(got)
  );
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cfg_wr(input gcc_cfg_s c);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_in <= c;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask
  // command held until taken, then wait for its response pulse
  task automatic host(input gcc_op_e op, input logic [7:0] d, input logic nk);
    @(posedge clk);
    cmd_v <= 1'b1;
    cmd <= '{op, d, nk};
    do
      @(posedge clk);
    while (rdy !== 1'b1);
    cmd_v <= 1'b0;
    do
      @(posedge clk);
    while (rsp_v !== 1'b1);
  endtask
  task automatic report_and_stop();
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    gcc_cfg_s   c;
    logic [6:0] exp;
    logic       en;
    int         nw;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check(cfg_out, CFG_RESET);
    check({sup_o, sup_oe, pd, dr_oe, cs_o, cs_oe, idle}, 7'b0110010);
    // six power/io combinations, then all pin functions unselected
    for (int i = 0; i < 7; i++)
    begin
      c = CFG_RESET;
      c.power_save = 1'b1;
      c.rx_power = i[0] | (i == 6);
      c.io_cfg = (i == 6) ? 8'h10 : 8'(i / 2 * 16);
      if (i == 6)
        c[19:11] = '0;
      en = i < 6 && c.rx_power && c.io_cfg == 8'h10;
      exp = {c.rx_power, i < 6, !en, 1'b0, i < 6 && c.rx_power && c.io_cfg == 8'h20, i < 6, 1'b1};
      cfg_wr(c);
      repeat (2) @(posedge clk);
      #1;
      check(cfg_out, c);
      check({sup_o, sup_oe, pd, dr_oe, cs_o, cs_oe, idle}, exp);
      @(posedge clk);
      dr <= 1'b1; // receiver signals readiness
      rtc <= 1'b0;
      nw = 0;
      repeat (8)
      begin
        @(posedge clk);
        #1;
        nw += (wake === 1'b1);
      end
      check(20'(nw), 20'(en));
      check({cs_o, idle}, {1'b0, !en});
      @(posedge clk);
      dr <= 1'b0;
      rtc <= 1'b1;
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(idle, 1'b1);
    end
    // address byte 0x2a with read bit, one read byte, master nack
    host(OP_START, 8'h00, 1'b0);
    #1;
    check(idle, 1'b0);
    host(OP_WRITE, 8'h55, 1'b0);
    check({got, rsp_nk}, {8'h55, 1'b0});
    host(OP_READ, 8'h00, 1'b1);
    check({rsp_d, rsp_nk}, {8'ha5, 1'b1});
    host(OP_STOP, 8'h00, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    check({scl, sda, scl_oe, sda_oe, scl_o, sda_o, idle}, 7'b1100001);
    // aiding save starts, then a reset in mid-sequence aborts it
    c = CFG_RESET;
    c.rx_power = 1'b1;
    c.local_aid = 1'b1;
    cfg_wr(c);
    @(posedge clk);
    aid_req <= 1'b1;
    @(posedge clk);
    aid_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check({aid_busy, rdy, aid_valid, idle}, 4'b1000);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check(cfg_out, CFG_RESET);
    check({aid_busy, aid_valid, rdy, scl_oe, sda_oe, wake, idle}, 7'b0010000);
    report_and_stop();
  end
  // the run needs about 50k cycles
  initial
  begin
    #(4 * 70000);
    fails++;
    report_and_stop();
  end
endmodule
bind gcc_top gcc_sva u_sva
(
  .CLK(CLK),
  .RESETN(RESETN),
  .CFG_OUT(CFG_OUT),
  .HOST_CMD_READY(HOST_CMD_READY),
  .COMPANION_SERIAL_BUS_SDA_OE(COMPANION_SERIAL_BUS_SDA_OE),
  .RECEIVER_SUPPLY_ENABLE_PIN_O(RECEIVER_SUPPLY_ENABLE_PIN_O),
  .RECEIVER_DATA_READY_PIN_I(RECEIVER_DATA_READY_PIN_I),
  .RECEIVER_DATA_READY_PIN_PD_EN(RECEIVER_DATA_READY_PIN_PD_EN),
  .CLOCK_SHARING_PIN_O(CLOCK_SHARING_PIN_O),
  .RTC_SYNC_IN(RTC_SYNC_IN),
  .WAKE_EVENT(WAKE_EVENT),
  .IDLE_REQ(IDLE_REQ)
);

// ==== rtl/gcc_pkg.sv ====
// constants and types shared by the receiver companion control block
package gcc_pkg;
  // pin function selections
  localparam logic [2:0] FN_SUPPLY = 3'h3;
  localparam logic [2:0] FN_READY  = 3'h4;
  localparam logic [2:0] FN_CLKSH  = 3'h5;
  // receiver io configuration values
  localparam logic [7:0] IO_CFG_READY = 8'h10;
  localparam logic [7:0] IO_CFG_CLKSH = 8'h20;
  // two-wire timing: quarter of a 100 kHz bit
  localparam int CLK_MHZ        = 250;
  localparam int I2C_QUARTER_NS = 2500;
  localparam int QUARTER_CYC    = (I2C_QUARTER_NS * CLK_MHZ) / 1000;
  localparam logic [9:0] QUARTER_LAST = 10'(QUARTER_CYC - 1);
  // aiding store and last bit index of a byte transfer
  localparam int AID_BYTES = 16;
  localparam logic [3:0] AID_LAST = 4'(AID_BYTES - 1);
  localparam logic [3:0] BIT_LAST = 4'h8;

  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_STOP  = 2'b11
  } gcc_op_e;

  typedef struct packed {
    gcc_op_e    op;
    logic [7:0] data;
    logic       nack;
  } gcc_cmd_s;

  typedef struct packed {
    logic [2:0] supply_func;
    logic [2:0] ready_func;
    logic [2:0] clksh_func;
    logic       rx_power;
    logic [7:0] io_cfg;
    logic       power_save;
    logic       local_aid;
  } gcc_cfg_s;

  localparam gcc_cfg_s CFG_RESET = '{FN_SUPPLY, FN_READY, FN_CLKSH, 1'b0, 8'h00, 1'b0, 1'b0};
endpackage

// ==== rtl/gcc_top.sv ====
// receiver companion control: two-wire master, receiver pins, idle and aiding
// Summary of operation
// - two-wire interface is master only; never answers as an addressed slave.
// - bus lines are only pulled low or released, never driven high.
// - supply-enable pin defaults to function value 3 after reset.
// - supply-enable pin follows receiver power setting; power setting resets to 0.
// - data-ready pin defaults to function value 4 after reset.
// - data-ready wakes only with power setting 1 and io configuration 16.
// - otherwise data-ready pin has output disabled and pull-down enabled.
// - clock-sharing pin defaults to function value 5.
// - clock-sharing pin outputs sync signal when power 1 and io config 32.
// - clock-sharing pin drives constant low when its conditions fail with function value 5 selected; otherwise output disabled.
// - with power saving on and no traffic pending, request idle.
// - data-ready indication wakes the device so no receiver data is lost.
// - local aiding saves receiver data locally and restores it on next power-up.
`timescale 1ns/1ps
module gcc_top
  import gcc_pkg::*;
#(
  parameter logic [6:0] RECEIVER_ADDR = 7'h10 // arbitrary default bus address
)(
  // clock and reset
  input  wire logic     CLK,
  input  wire logic     RESETN,
  // configuration
  input  wire logic     CFG_WE,
  input  wire gcc_cfg_s CFG_IN,
  output gcc_cfg_s      CFG_OUT,
  // host byte commands on the companion serial bus
  input  wire logic     HOST_CMD_VALID,
  input  wire gcc_cmd_s HOST_CMD,
  output logic          HOST_CMD_READY,
  output logic          HOST_RSP_VALID,
  output logic [7:0]    HOST_RSP_DATA,
  output logic          HOST_RSP_NACK,
  // companion serial bus pins
  input  wire logic     COMPANION_SERIAL_BUS_SCL_I,
  output logic          COMPANION_SERIAL_BUS_SCL_O,
  output logic          COMPANION_SERIAL_BUS_SCL_OE,
  input  wire logic     COMPANION_SERIAL_BUS_SDA_I,
  output logic          COMPANION_SERIAL_BUS_SDA_O,
  output logic          COMPANION_SERIAL_BUS_SDA_OE,
  // receiver pins
  output logic          RECEIVER_SUPPLY_ENABLE_PIN_O,
  output logic          RECEIVER_SUPPLY_ENABLE_PIN_OE,
  input  wire logic     RECEIVER_DATA_READY_PIN_I,
  output logic          RECEIVER_DATA_READY_PIN_OE,
  output logic          RECEIVER_DATA_READY_PIN_PD_EN,
  output logic          CLOCK_SHARING_PIN_O,
  output logic          CLOCK_SHARING_PIN_OE,
  input  wire logic     RTC_SYNC_IN,
  // power management and aiding
  output logic          WAKE_EVENT,
  input  wire logic     WAKE_ACK,
  output logic          IDLE_REQ,
  input  wire logic     AID_SAVE_REQ,
  output logic          AID_VALID,
  output logic          AID_BUSY
);

  typedef enum logic [1:0] {
    ES_IDLE  = 2'b00,
    ES_START = 2'b01,
    ES_BIT   = 2'b10,
    ES_STOP  = 2'b11
  } gcc_eng_e;

  typedef enum logic [2:0] {
    AQ_IDLE  = 3'b000,
    AQ_START = 3'b001,
    AQ_ADDR  = 3'b010,
    AQ_DATA  = 3'b011,
    AQ_STOP  = 3'b100
  } gcc_aq_e;

  gcc_cfg_s   cfg_q;
  gcc_eng_e   es_q;
  gcc_aq_e    aq_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [9:0] qcnt_q;
  logic [8:0] sh_q;
  logic [8:0] rx_q;
  logic       scl_pull_q;
  logic       sda_pull_q;
  logic       done_q;
  logic       owner_host_q;
  logic       host_claim_q;
  logic       rsp_valid_q;
  logic [3:0] idx_q;
  logic       aq_wait_q;
  logic       save_q;
  logic       aid_ok_q;
  logic       aid_valid_q;
  logic       save_pend_q;
  logic       restore_pend_q;
  logic       power_prev_q;
  logic       drs1_q;
  logic       drs2_q;
  logic       drs3_q;
  logic       wake_pend_q;
  logic       wake_q;
  logic       idle_q;
  logic       clksh_q;
  logic [7:0] aid_mem [AID_BYTES];

  // configuration decode
  wire ready_en  = cfg_q.ready_func == FN_READY && cfg_q.rx_power
                   && cfg_q.io_cfg == IO_CFG_READY;
  wire clksh_en  = cfg_q.clksh_func == FN_CLKSH && cfg_q.rx_power
                   && cfg_q.io_cfg == IO_CFG_CLKSH;
  wire supply_fn = cfg_q.supply_func == FN_SUPPLY;
  wire power_up  = cfg_q.rx_power & ~power_prev_q;

  // byte engine handshake and arbitration; sequence owns the bus while active
  wire      seq_act   = aq_q != AQ_IDLE;
  wire      seq_valid = seq_act & ~aq_wait_q;
  wire      eng_ready = es_q == ES_IDLE;
  gcc_cmd_s seq_cmd;
  always_comb
  begin
    seq_cmd = '{OP_STOP, 8'h00, 1'b0};
    case (aq_q)
      AQ_START: seq_cmd = '{OP_START, 8'h00, 1'b0};
      AQ_ADDR:  seq_cmd = '{OP_WRITE, {RECEIVER_ADDR, save_q}, 1'b0};
      AQ_DATA:  seq_cmd = save_q ? gcc_cmd_s'{OP_READ, 8'h00, idx_q == AID_LAST}
                                 : gcc_cmd_s'{OP_WRITE, aid_mem[idx_q], 1'b0};
      default:  seq_cmd = '{OP_STOP, 8'h00, 1'b0};
    endcase
  end
  wire      cmd_valid = seq_act ? seq_valid : HOST_CMD_VALID;
  gcc_cmd_s cmd;
  assign cmd    = seq_act ? seq_cmd : HOST_CMD;
  wire eng_go   = eng_ready & cmd_valid;
  wire host_go  = eng_go & ~seq_act;

  // quarter-bit timer; a slave holding the clock low stretches the high phase
  wire tick    = qcnt_q == QUARTER_LAST;
  wire stretch = es_q == ES_BIT && phase_q == 2'h2 && !COMPANION_SERIAL_BUS_SCL_I;
  wire step    = tick & ~stretch;

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      qcnt_q <= 10'h000;
    else if (eng_ready || step)
      qcnt_q <= 10'h000;
    else if (!tick)
      qcnt_q <= qcnt_q + 10'h001;
  end

  // byte engine: master only, no address match logic exists at all
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      es_q         <= ES_IDLE;
      phase_q      <= 2'h0;
      bit_q        <= 4'h0;
      sh_q         <= 9'h1ff;
      rx_q         <= 9'h000;
      scl_pull_q   <= 1'b0;
      sda_pull_q   <= 1'b0;
      done_q       <= 1'b0;
      owner_host_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (eng_go)
      begin
        phase_q      <= 2'h0;
        bit_q        <= 4'h0;
        owner_host_q <= ~seq_act;
        sh_q         <= (cmd.op == OP_READ) ? {8'hff, cmd.nack} : {cmd.data, 1'b1};
        case (cmd.op)
          OP_START: es_q <= ES_START;
          OP_STOP:  es_q <= ES_STOP;
          default:  es_q <= ES_BIT;
        endcase
      end
      else if (step && !eng_ready)
      begin
        phase_q <= phase_q + 2'h1;
        case (es_q)
          ES_START:
          begin
            // release first so a repeated start also works
            case (phase_q)
              2'h0:    sda_pull_q <= 1'b0;
              2'h1:    scl_pull_q <= 1'b0;
              2'h2:    sda_pull_q <= 1'b1;
              default: scl_pull_q <= 1'b1;
            endcase
            if (phase_q == 2'h3)
            begin
              es_q   <= ES_IDLE;
              done_q <= 1'b1;
            end
          end
          ES_BIT:
          begin
            case (phase_q)
              2'h0:    sda_pull_q <= ~sh_q[8];
              2'h1:    scl_pull_q <= 1'b0;
              2'h2:    rx_q       <= {rx_q[7:0], COMPANION_SERIAL_BUS_SDA_I};
              default: scl_pull_q <= 1'b1;
            endcase
            if (phase_q == 2'h3)
            begin
              sh_q  <= {sh_q[7:0], 1'b1};
              bit_q <= bit_q + 4'h1;
              if (bit_q == BIT_LAST)
              begin
                es_q   <= ES_IDLE;
                done_q <= 1'b1;
              end
            end
          end
          ES_STOP:
          begin
            case (phase_q)
              2'h0:    sda_pull_q <= 1'b1;
              2'h1:    scl_pull_q <= 1'b0;
              default: sda_pull_q <= 1'b0;
            endcase
            if (phase_q == 2'h2)
            begin
              es_q   <= ES_IDLE;
              done_q <= 1'b1;
            end
          end
          default: es_q <= ES_IDLE;
        endcase
      end
    end
  end

  // host side bookkeeping
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      host_claim_q <= 1'b0;
      rsp_valid_q  <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= done_q & owner_host_q;
      if (host_go && cmd.op == OP_START)
        host_claim_q <= 1'b1;
      else if (host_go && cmd.op == OP_STOP)
        host_claim_q <= 1'b0;
    end
  end

  // aiding sequencer: read receiver data out, write it back at power-up
  wire seq_done  = done_q & ~owner_host_q & aq_wait_q;
  wire launch_ok = aq_q == AQ_IDLE && eng_ready && !host_claim_q;
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      aq_q           <= AQ_IDLE;
      aq_wait_q      <= 1'b0;
      save_q         <= 1'b0;
      idx_q          <= 4'h0;
      aid_ok_q       <= 1'b0;
      aid_valid_q    <= 1'b0;
      save_pend_q    <= 1'b0;
      restore_pend_q <= 1'b0;
    end
    else
    begin
      if (AID_SAVE_REQ && cfg_q.local_aid && cfg_q.rx_power)
        save_pend_q <= 1'b1;
      if (power_up && cfg_q.local_aid && aid_valid_q)
        restore_pend_q <= 1'b1;
      if (launch_ok && (restore_pend_q || save_pend_q))
      begin
        // restore first: a fresh receiver needs its data before any new save
        save_q   <= ~restore_pend_q;
        if (restore_pend_q)
          restore_pend_q <= power_up && cfg_q.local_aid && aid_valid_q;
        else
          save_pend_q <= AID_SAVE_REQ && cfg_q.local_aid && cfg_q.rx_power;
        aq_q     <= AQ_START;
        idx_q    <= 4'h0;
        aid_ok_q <= 1'b1;
      end
      if (eng_go && seq_act)
        aq_wait_q <= 1'b1;
      if (seq_done)
      begin
        aq_wait_q <= 1'b0;
        case (aq_q)
          AQ_START: aq_q <= AQ_ADDR;
          AQ_ADDR:
          begin
            aq_q     <= rx_q[0] ? AQ_STOP : AQ_DATA;
            aid_ok_q <= ~rx_q[0];
          end
          AQ_DATA:
          begin
            idx_q <= idx_q + 4'h1;
            if ((!save_q && rx_q[0]) || idx_q == AID_LAST)
              aq_q <= AQ_STOP;
            if (!save_q && rx_q[0])
              aid_ok_q <= 1'b0;
          end
          default:
          begin
            aq_q <= AQ_IDLE;
            if (save_q)
              aid_valid_q <= aid_ok_q;
          end
        endcase
      end
    end
  end

  // aiding store has no reset; its contents count only once marked valid
  always_ff @(posedge CLK)
  begin
    if (seq_done && aq_q == AQ_DATA && save_q)
      aid_mem[idx_q] <= rx_q[8:1];
  end

  // configuration with power-on defaults
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      cfg_q        <= CFG_RESET;
      power_prev_q <= 1'b0;
    end
    else
    begin
      power_prev_q <= cfg_q.rx_power;
      if (CFG_WE)
        cfg_q <= CFG_IN;
    end
  end

  // data-ready sampling and wake; first stage feeds only the second
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      drs1_q      <= 1'b0;
      drs2_q      <= 1'b0;
      drs3_q      <= 1'b0;
      wake_pend_q <= 1'b0;
      wake_q      <= 1'b0;
    end
    else
    begin
      drs1_q <= RECEIVER_DATA_READY_PIN_I;
      drs2_q <= drs1_q;
      drs3_q <= drs2_q;
      wake_q <= ready_en & drs2_q & ~drs3_q;
      // a new indication wins over an acknowledge in the same cycle
      if (ready_en && drs2_q && !drs3_q)
        wake_pend_q <= 1'b1;
      else if (WAKE_ACK)
        wake_pend_q <= 1'b0;
    end
  end

  // idle request and clock-sharing output
  wire pending = !eng_ready || seq_act || host_claim_q || wake_pend_q
                 || save_pend_q || restore_pend_q;
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      idle_q  <= 1'b0;
      clksh_q <= 1'b0;
    end
    else
    begin
      idle_q  <= cfg_q.power_save & ~pending;
      clksh_q <= clksh_en & RTC_SYNC_IN;
    end
  end

  // pins: bus lines open drain, output value always low
  assign COMPANION_SERIAL_BUS_SCL_O    = 1'b0;
  assign COMPANION_SERIAL_BUS_SDA_O    = 1'b0;
  assign COMPANION_SERIAL_BUS_SCL_OE   = scl_pull_q;
  assign COMPANION_SERIAL_BUS_SDA_OE   = sda_pull_q;
  assign RECEIVER_SUPPLY_ENABLE_PIN_O  = cfg_q.rx_power;
  assign RECEIVER_SUPPLY_ENABLE_PIN_OE = supply_fn;
  assign RECEIVER_DATA_READY_PIN_OE    = 1'b0;
  assign RECEIVER_DATA_READY_PIN_PD_EN = ~ready_en;
  assign CLOCK_SHARING_PIN_O           = clksh_q;
  assign CLOCK_SHARING_PIN_OE          = cfg_q.clksh_func == FN_CLKSH;
  assign CFG_OUT                       = cfg_q;
  assign HOST_CMD_READY                = eng_ready & ~seq_act;
  assign HOST_RSP_VALID                = rsp_valid_q;
  assign HOST_RSP_DATA                 = rx_q[8:1];
  assign HOST_RSP_NACK                 = rx_q[0];
  assign WAKE_EVENT                    = wake_q;
  assign IDLE_REQ                      = idle_q;
  assign AID_VALID                     = aid_valid_q;
  assign AID_BUSY                      = seq_act;

endmodule
